// File: design/hostport_pkg.sv
// Purpose: Shared constants and state types for the host bus FIFO port
// Assumes: 100 MHz clk, times below converted to whole cycles
// Notes:   Least times round up, longest times round down, never below one cycle
package hostport_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DATA_W        = 32;
  localparam int HALF_W        = 16;
  localparam int ADDR_HI       = 7;
  localparam int ADDR_LO       = 1;
  localparam int HALF_SEL_BIT  = 1;  // A1 picks the 16-bit half
  localparam int BUF_DEPTH     = 2;
  localparam int CNT_W         = 8;
  localparam int LEN_W         = 6;
  localparam int PIN_W         = 5 + ADDR_HI - ADDR_LO + 1 + DATA_W;

  // Host strobe timing (least times)
  localparam int T_CSL_NS = 32;
  localparam int T_CSH_NS = 13;
  localparam int CSL_CYC  = (T_CSL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CSH_CYC  = (T_CSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_LAT_CYC   = 4;  // Pin sync and output register round trip
  localparam int SEEN_CYC     = 2;  // Lets the device synchroniser see a high
  localparam int HOST_LOW_CYC  = CSL_CYC + RD_LAT_CYC;
  localparam int HOST_HIGH_CYC = CSH_CYC + SEEN_CYC;

  // Output drive after reset release (longest time)
  localparam int T_DRIVE_NS = 16;
  localparam int DRIVE_CYC  = (T_DRIVE_NS / CLK_PERIOD_NS < 1) ? 1 : T_DRIVE_NS / CLK_PERIOD_NS;

  // Serial PROM timing (least times)
  localparam int T_CKH_NS    = 550;
  localparam int T_CKL_NS    = 550;
  localparam int T_CSHCKH_NS = 1070;
  localparam int T_CKLCSL_NS = 30;
  localparam int T_CSLOW_NS  = 1070;
  localparam int CKH_CYC    = (T_CKH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CKL_CYC    = (T_CKL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CSHCKH_CYC = (T_CSHCKH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CKLCSL_CYC = (T_CKLCSL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CSLOW_CYC  = (T_CSLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Setup phase plus first low phase covers the select-to-clock lead
  localparam int SETUP_CYC  = (CSHCKH_CYC > CKL_CYC) ? CSHCKH_CYC - CKL_CYC : 1;

  typedef enum logic [5:0] {
    P_IDLE  = 6'h01,
    P_SETUP = 6'h02,
    P_LOW   = 6'h04,
    P_HIGH  = 6'h08,
    P_HOLD  = 6'h10,
    P_GAP   = 6'h20
  } prom_state_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_LOW  = 3'h2,
    H_HIGH = 3'h4
  } host_state_e;
endpackage : hostport_pkg

// File: design/host_bus_if.sv
// Purpose: SRAM-like bus pins between host and device
// Assumes: Enables are active low; undriven lanes read as ones
// Notes:   The shared data wire is resolved here from both ends
`timescale 1ns/1ps
interface host_bus_if import hostport_pkg::*; ();
  logic                 bus_select_n;
  logic                 read_strobe_n;
  logic                 write_strobe_n;
  logic                 fifo_select;
  logic [ADDR_HI:ADDR_LO] addr;
  logic [DATA_W-1:0]    host_data;
  logic                 host_data_oe_n;
  logic [DATA_W-1:0]    dev_data;
  logic                 dev_lo_oe_n;
  logic                 dev_hi_oe_n;
  logic [DATA_W-1:0]    bus_data;

  // Wire level per lane from the enables
  assign bus_data[HALF_W-1:0] = !dev_lo_oe_n ? dev_data[HALF_W-1:0] :
                                !host_data_oe_n ? host_data[HALF_W-1:0] : '1;
  assign bus_data[DATA_W-1:HALF_W] = !dev_hi_oe_n ? dev_data[DATA_W-1:HALF_W] :
                                     !host_data_oe_n ? host_data[DATA_W-1:HALF_W] : '1;

  modport device (input bus_select_n, read_strobe_n, write_strobe_n, fifo_select, addr,
                  bus_data, output dev_data, dev_lo_oe_n, dev_hi_oe_n);
  modport host (output bus_select_n, read_strobe_n, write_strobe_n, fifo_select, addr,
                host_data, host_data_oe_n, input bus_data);
endinterface : host_bus_if

// File: design/two_entry_buffer.sv
// Purpose: Small valid/ready buffer in a data path
// Assumes: Single clock, pop and push may share a cycle
// Notes:   in_ready low when full, out_valid low when empty
`timescale 1ns/1ps
module two_entry_buffer
  import hostport_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0]   mem_reg [DEPTH];
  logic [PTR_W-1:0]   wr_ptr_reg;
  logic [PTR_W-1:0]   rd_ptr_reg;
  logic [PTR_W:0]     count_reg;
  logic               push;
  logic               pop;

  // Handshakes from the fill count
  assign in_ready  = (count_reg != (PTR_W+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end
endmodule : two_entry_buffer

// File: design/fifo_port_device.sv
// Purpose: Device end of the SRAM-like port with FIFO direct access and PROM strobes
// Assumes: Bus pins arrive asynchronously; rst stands for the device reset pin
// Notes:   Non-FIFO reads return a snapshot of the access counter
`timescale 1ns/1ps
// Summary of operation
// - FIFO select read returns receive data
// - Burst reads have no length limit
// - Reads decode A1 only, ignore A7..A2
// - Upper lanes undriven in 16-bit reads
// - Read cycle spans select and read low
// - Host holds strobe high between bursts
// - All writes use the write cycle
// - Upper lanes ignored in 16-bit writes
// - Write cycle spans select and write low
// - FIFO select write pushes transmit data
// - Writes decode A1 only, ignore A7..A2
// - FIFO write framed by both strobes
// - Straps captured at reset release
// - Outputs driven only after reset release
// - PROM select rises well before clock
// - PROM select drops after clock falls
// - PROM data presented before rising edge
// - PROM data sampled at rising edge
// - Counter snapshot taken at read start
module fifo_port_device
  import hostport_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  host_bus_if.device             bus,
  input  wire logic              bus16_strap,
  output logic                   bus16_mode,
  input  wire logic [DATA_W-1:0] rx_data,
  input  wire logic              rx_valid,
  output logic                   rx_ready,
  output logic [DATA_W-1:0]      tx_data,
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output logic                   tx_overrun,
  input  wire logic              prom_start,
  input  wire logic [LEN_W-1:0]  prom_out_len,
  input  wire logic [LEN_W-1:0]  prom_in_len,
  input  wire logic [DATA_W-1:0] prom_cmd,
  output logic                   prom_busy,
  output logic                   prom_done,
  output logic [DATA_W-1:0]      prom_rd_data,
  output logic                   serial_prom_clock,
  output logic                   serial_prom_select,
  input  wire logic              serial_prom_data_in,
  output logic                   serial_prom_data_out,
  output logic                   serial_prom_data_oe_n
);
  logic [PIN_W-1:0]   sync1_reg;
  logic [PIN_W-1:0]   sync2_reg;
  logic               strap1_reg;
  logic               strap2_reg;
  logic               live_reg;
  logic               cs_n;
  logic               rd_n;
  logic               wr_n;
  logic               fsel;
  logic               pdin;
  logic [ADDR_HI:ADDR_LO] a_s;
  logic [DATA_W-1:0]  d_s;
  logic               rd_act;
  logic               wr_act;
  logic               rd_act_reg;
  logic               wr_act_reg;
  logic               rd_start;
  logic               wr_end;
  logic [DATA_W-1:0]  dout_reg;
  logic [DATA_W-1:0]  wdata_reg;
  logic               wfifo_reg;
  logic               whalf_reg;
  logic [HALF_W-1:0]  lo_half_reg;
  logic [DATA_W-1:0]  acc_cnt_reg;
  logic [DATA_W-1:0]  rb_data;
  logic               rb_valid;
  logic               rb_pop;
  logic               tb_push;
  logic               tb_ready;
  logic [DATA_W-1:0]  tb_data;
  logic               overrun_reg;

  // Word is done in 32-bit mode, or on the upper half in 16-bit mode
  function automatic logic word_done(input logic narrow, input logic half_sel);
    word_done = !narrow || half_sel;
  endfunction : word_done

  // Two-stage synchroniser for every pin input
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= {bus.bus_select_n, bus.read_strobe_n, bus.write_strobe_n,
                    bus.fifo_select, serial_prom_data_in, bus.addr, bus.bus_data};
      sync2_reg <= sync1_reg;
    end
  end
  assign {cs_n, rd_n, wr_n, fsel, pdin, a_s, d_s} = sync2_reg;

  // Strap synchroniser runs through reset so its level is ready at release
  always_ff @(posedge clk) begin
    strap1_reg <= bus16_strap;
    strap2_reg <= strap1_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      live_reg   <= 1'b0;
      bus16_mode <= 1'b0;
    end else if (!live_reg) begin
      live_reg   <= 1'b1;
      bus16_mode <= strap2_reg;
    end
  end

  assign rd_act   = !cs_n && !rd_n;
  assign wr_act   = !cs_n && !wr_n;
  assign rd_start = rd_act && !rd_act_reg;
  assign wr_end   = !wr_act && wr_act_reg;

  // Frame history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_act_reg <= 1'b0;
      wr_act_reg <= 1'b0;
    end else begin
      rd_act_reg <= rd_act;
      wr_act_reg <= wr_act;
    end
  end

  // Receive path buffer
  two_entry_buffer #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH)) rx_buf (
    .clk       (clk),
    .rst       (rst),
    .in_data   (rx_data),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (rb_data),
    .out_valid (rb_valid),
    .out_ready (rb_pop)
  );

  assign rb_pop = rd_start && fsel && rb_valid && word_done(bus16_mode, a_s[HALF_SEL_BIT]);

  // FIFO read data, every start served
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout_reg <= '0;
    end else if (rd_start) begin
      if (fsel) begin
        if (!rb_valid) begin
          dout_reg <= '0;
        end else if (bus16_mode) begin
          dout_reg <= {{HALF_W{1'b0}}, a_s[HALF_SEL_BIT] ? rb_data[DATA_W-1:HALF_W]
                                                         : rb_data[HALF_W-1:0]};
        end else begin
          dout_reg <= rb_data;
        end
      end else begin
        dout_reg <= acc_cnt_reg;
      end
    end
  end

  // Access counter, one step per read start or write end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_cnt_reg <= '0;
    end else if (rd_start || wr_end) begin
      acc_cnt_reg <= acc_cnt_reg + 1'b1;
    end
  end

  // lanes stay off until release; upper lanes off in 16-bit mode
  assign bus.dev_data    = dout_reg;
  assign bus.dev_lo_oe_n = !(live_reg && rd_act);
  assign bus.dev_hi_oe_n = !(live_reg && rd_act && !bus16_mode);

  // track write data while the frame is open
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdata_reg <= '0;
      wfifo_reg <= 1'b0;
      whalf_reg <= 1'b0;
    end else if (wr_act) begin
      wdata_reg <= d_s;
      wfifo_reg <= fsel;
      whalf_reg <= a_s[HALF_SEL_BIT];
    end
  end

  // lower half kept on A1 low; upper lanes dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lo_half_reg <= '0;
    end else if (wr_end && wfifo_reg && bus16_mode && !whalf_reg) begin
      lo_half_reg <= wdata_reg[HALF_W-1:0];
    end
  end

  // Word-ending FIFO writes push transmit data, non-FIFO writes are dropped
  assign tb_push = wr_end && wfifo_reg && word_done(bus16_mode, whalf_reg);
  assign tb_data = bus16_mode ? {wdata_reg[HALF_W-1:0], lo_half_reg} : wdata_reg;

  // Transmit path buffer
  two_entry_buffer #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH)) tx_buf (
    .clk       (clk),
    .rst       (rst),
    .in_data   (tb_data),
    .in_valid  (tb_push),
    .in_ready  (tb_ready),
    .out_data  (tx_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );

  // Sticky flag: a write met a full buffer and was lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overrun_reg <= 1'b0;
    end else if (tb_push && !tb_ready) begin
      overrun_reg <= 1'b1;
    end
  end
  assign tx_overrun = overrun_reg;

  // Serial PROM engine
  prom_state_e        pstate_reg;
  logic [CNT_W-1:0]   tcnt_reg;
  logic [LEN_W:0]     bits_reg;
  logic [LEN_W:0]     outs_reg;
  logic [DATA_W-1:0]  shout_reg;
  logic [DATA_W-1:0]  shin_reg;
  logic               tdone;

  assign tdone     = (tcnt_reg == '0);
  assign prom_busy = (pstate_reg != P_IDLE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pstate_reg            <= P_IDLE;
      tcnt_reg              <= '0;
      bits_reg              <= '0;
      outs_reg              <= '0;
      shout_reg             <= '0;
      shin_reg              <= '0;
      prom_rd_data          <= '0;
      prom_done             <= 1'b0;
      serial_prom_clock     <= 1'b0;
      serial_prom_select    <= 1'b0;
      serial_prom_data_out  <= 1'b0;
      serial_prom_data_oe_n <= 1'b1;
    end else begin
      prom_done <= 1'b0;
      if (!tdone) begin
        tcnt_reg <= tcnt_reg - 1'b1;
      end
      case (pstate_reg)
        P_IDLE: begin
          if (prom_start) begin
            // select high ahead of the first clock
            serial_prom_select <= 1'b1;
            bits_reg   <= (LEN_W+1)'(prom_out_len) + (LEN_W+1)'(prom_in_len);
            outs_reg   <= (LEN_W+1)'(prom_out_len);
            shout_reg  <= prom_cmd;
            shin_reg   <= '0;
            tcnt_reg   <= CNT_W'(SETUP_CYC - 1);
            pstate_reg <= P_SETUP;
          end
        end
        P_SETUP, P_LOW: begin
          if (pstate_reg == P_SETUP && tdone) begin
            // bit presented a full low phase before the rise
            serial_prom_data_out  <= shout_reg[DATA_W-1];
            serial_prom_data_oe_n <= (outs_reg == '0);
            tcnt_reg   <= CNT_W'(CKL_CYC - 1);
            pstate_reg <= (bits_reg == '0) ? P_HOLD : P_LOW;
          end else if (pstate_reg == P_LOW && tdone) begin
            serial_prom_clock <= 1'b1;
            if (outs_reg == '0) begin
              shin_reg <= {shin_reg[DATA_W-2:0], pdin};
            end
            tcnt_reg   <= CNT_W'(CKH_CYC - 1);
            pstate_reg <= P_HIGH;
          end
        end
        P_HIGH: begin
          if (tdone) begin
            serial_prom_clock <= 1'b0;
            bits_reg  <= bits_reg - 1'b1;
            if (outs_reg != '0) begin
              outs_reg <= outs_reg - 1'b1;
            end
            shout_reg <= {shout_reg[DATA_W-2:0], 1'b0};
            // next bit only after the high phase
            serial_prom_data_out  <= shout_reg[DATA_W-2];
            serial_prom_data_oe_n <= (outs_reg <= (LEN_W+1)'(1));
            if (bits_reg == (LEN_W+1)'(1)) begin
              serial_prom_data_oe_n <= 1'b1;
              tcnt_reg   <= CNT_W'(CKLCSL_CYC - 1);
              pstate_reg <= P_HOLD;
            end else begin
              tcnt_reg   <= CNT_W'(CKL_CYC - 1);
              pstate_reg <= P_LOW;
            end
          end
        end
        P_HOLD: begin
          if (tdone) begin
            // select drops after the falling edge
            serial_prom_select <= 1'b0;
            tcnt_reg   <= CNT_W'(CSLOW_CYC - 1);
            pstate_reg <= P_GAP;
          end
        end
        P_GAP: begin
          if (tdone) begin
            prom_rd_data <= shin_reg;
            prom_done    <= 1'b1;
            pstate_reg   <= P_IDLE;
          end
        end
        default: begin
          pstate_reg <= P_IDLE;
        end
      endcase
    end
  end
endmodule : fifo_port_device

// File: design/fifo_port_host.sv
// Purpose: Host end driving read and write cycles on the SRAM-like port
// Assumes: One command at a time; bus16_mode matches the device strap
// Notes:   Both strobes rise between cycles and stay high for the gap
`timescale 1ns/1ps
module fifo_port_host
  import hostport_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  host_bus_if.host                    bus,
  input  wire logic                   bus16_mode,
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire logic                   cmd_write,
  input  wire logic                   cmd_fifo,
  input  wire logic [ADDR_HI:ADDR_LO] cmd_addr,
  input  wire logic [DATA_W-1:0]      cmd_wdata,
  output logic                        rsp_valid,
  output logic [DATA_W-1:0]           rsp_data
);
  host_state_e        hstate_reg;
  logic [CNT_W-1:0]   hcnt_reg;
  logic               write_reg;
  logic [DATA_W-1:0]  dsync1_reg;
  logic [DATA_W-1:0]  dsync2_reg;

  assign cmd_ready = (hstate_reg == H_IDLE);

  // Read data synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dsync1_reg <= '0;
      dsync2_reg <= '0;
    end else begin
      dsync1_reg <= bus.bus_data;
      dsync2_reg <= dsync1_reg;
    end
  end

  // frame both strobes; both rise for the gap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hstate_reg         <= H_IDLE;
      hcnt_reg           <= '0;
      write_reg          <= 1'b0;
      bus.bus_select_n   <= 1'b1;
      bus.read_strobe_n  <= 1'b1;
      bus.write_strobe_n <= 1'b1;
      bus.fifo_select    <= 1'b0;
      bus.addr           <= '0;
      bus.host_data      <= '0;
      bus.host_data_oe_n <= 1'b1;
      rsp_valid          <= 1'b0;
      rsp_data           <= '0;
    end else begin
      rsp_valid <= 1'b0;
      case (hstate_reg)
        H_IDLE: begin
          if (cmd_valid) begin
            write_reg          <= cmd_write;
            bus.fifo_select    <= cmd_fifo;
            bus.addr           <= cmd_addr;
            bus.host_data      <= cmd_wdata;
            bus.host_data_oe_n <= !cmd_write;
            bus.bus_select_n   <= 1'b0;
            bus.read_strobe_n  <= cmd_write;
            bus.write_strobe_n <= !cmd_write;
            hcnt_reg           <= CNT_W'(HOST_LOW_CYC - 1);
            hstate_reg         <= H_LOW;
          end
        end
        H_LOW: begin
          if (hcnt_reg == '0) begin
            bus.bus_select_n   <= 1'b1;
            bus.read_strobe_n  <= 1'b1;
            bus.write_strobe_n <= 1'b1;
            if (!write_reg) begin
              rsp_valid <= 1'b1;
              // upper lanes meaningless in 16-bit mode
              rsp_data  <= bus16_mode ? {{HALF_W{1'b0}}, dsync2_reg[HALF_W-1:0]}
                                      : dsync2_reg;
            end
            hcnt_reg   <= CNT_W'(HOST_HIGH_CYC - 1);
            hstate_reg <= H_HIGH;
          end else begin
            hcnt_reg <= hcnt_reg - 1'b1;
          end
        end
        H_HIGH: begin
          // Data held past the strobe rise, then released
          bus.host_data_oe_n <= 1'b1;
          if (hcnt_reg == '0) begin
            hstate_reg <= H_IDLE;
          end else begin
            hcnt_reg <= hcnt_reg - 1'b1;
          end
        end
        default: begin
          hstate_reg <= H_IDLE;
        end
      endcase
    end
  end
endmodule : fifo_port_host

// File: tb/hostport_checker.sv
// Purpose: Bus checks on the link between host and device ends
// Assumes: One clock, reset active high
// Notes:   Watches interface signals only
`timescale 1ns/1ps
module hostport_checker
  import hostport_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   bus_select_n,
  input wire logic                   read_strobe_n,
  input wire logic                   write_strobe_n,
  input wire logic                   fifo_select,
  input wire logic [ADDR_HI:ADDR_LO] addr,
  input wire logic                   host_data_oe_n,
  input wire logic [DATA_W-1:0]      dev_data,
  input wire logic                   dev_lo_oe_n,
  input wire logic                   dev_hi_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Read frame open on both strobes
  wire rd_on = !bus_select_n && !read_strobe_n;
  lane_on_a: assert property ($rose(rd_on) |-> ##2 !dev_lo_oe_n)
    else $error("lanes not on after read start");
  lane_off_a: assert property ($fell(rd_on) |-> ##2 dev_lo_oe_n)
    else $error("lanes not off after read end");
  drive_cause_a: assert property (!dev_lo_oe_n |-> $past(rd_on, 2))
    else $error("lanes driven without read");
  hi_with_lo_a: assert property (!dev_hi_oe_n |-> !dev_lo_oe_n)
    else $error("upper lane alone");
  wr_quiet_a: assert property (!write_strobe_n |-> dev_lo_oe_n && dev_hi_oe_n)
    else $error("device drives in write");
  dout_hold_a: assert property (!dev_lo_oe_n && $past(!dev_lo_oe_n, 2) |-> $stable(dev_data))
    else $error("read data moved");
  gap_min_a: assert property ($rose(bus_select_n) |-> bus_select_n [*2])
    else $error("select gap short");
  low_min_a: assert property ($fell(bus_select_n) |-> !bus_select_n [*4])
    else $error("select low short");
  addr_hold_a: assert property (!bus_select_n && $past(!bus_select_n)
    |-> $stable(addr) && $stable(fifo_select))
    else $error("address moved in frame");
  wr_drive_a: assert property (!write_strobe_n && !bus_select_n |-> !host_data_oe_n)
    else $error("write data undriven");
endmodule : hostport_checker

// File: tb/host_bus_fifo_direct_port_tb_top.sv
// Purpose: Self-checking bench joining host and device ends
// Assumes: 100 MHz clock, strap set during reset
// Notes:   Serial PROM runs one fixed frame of two bits out and two bits in
`timescale 1ns/1ps
module host_bus_fifo_direct_port_tb_top
  import hostport_pkg::*;
;
  logic clk, rst, bus16_strap, bus16_mode, rx_valid, rx_ready, tx_valid, tx_ready, tx_overrun;
  logic cmd_valid, cmd_ready, cmd_write, cmd_fifo, rsp_valid;
  logic hi16 = 1'h0;
  logic [ADDR_HI:ADDR_LO] cmd_addr;
  logic [DATA_W-1:0] rx_data, tx_data, cmd_wdata, rsp_data, rd;
  logic prom_start = 1'h0, sp_din = 1'h0, prom_busy, prom_done;
  logic sp_clk, sp_sel, sp_dout, sp_oe_n;
  logic [DATA_W-1:0] prom_rd_data;
  int error_cnt = 0;
  int n_tests = 0;
  host_bus_if hb ();
  fifo_port_device i_fifo_port_device (.clk, .rst, .bus(hb), .bus16_strap, .bus16_mode,
    .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready, .tx_overrun,
    .prom_start, .prom_out_len(6'h02), .prom_in_len(6'h02), .prom_cmd(32'h8000_0000),
    .prom_busy, .prom_done, .prom_rd_data, .serial_prom_clock(sp_clk),
    .serial_prom_select(sp_sel), .serial_prom_data_in(sp_din), .serial_prom_data_out(sp_dout),
    .serial_prom_data_oe_n(sp_oe_n));
  fifo_port_host i_fifo_port_host (.clk, .rst, .bus(hb), .bus16_mode, .cmd_valid, .cmd_ready,
    .cmd_write, .cmd_fifo, .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_data);
  hostport_checker i_hostport_checker (.clk, .rst, .bus_select_n(hb.bus_select_n),
    .read_strobe_n(hb.read_strobe_n), .write_strobe_n(hb.write_strobe_n),
    .fifo_select(hb.fifo_select), .addr(hb.addr), .host_data_oe_n(hb.host_data_oe_n),
    .dev_data(hb.dev_data), .dev_lo_oe_n(hb.dev_lo_oe_n), .dev_hi_oe_n(hb.dev_hi_oe_n));
  // Clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Note any upper lane drive in 16-bit mode
  always @(posedge clk) if (bus16_mode === 1'h1 && hb.dev_hi_oe_n === 1'h0) hi16 <= 1'h1;
  task automatic chk(string nm, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic do_reset(logic strap);
    rst = 1'h1;
    bus16_strap = strap;
    repeat (16) @(posedge clk);
    #1 rst = 1'h0;
  endtask : do_reset
  task automatic push(logic [DATA_W-1:0] d);
    @(posedge clk);
    #1 rx_data = d;
    rx_valid = 1'h1;
    for (int k = 0; k < 50 && !rx_ready; k++) @(posedge clk) #1;
    chk("rx_ready", 32'h1, {31'h0, rx_ready});
    @(posedge clk) #1 rx_valid = 1'h0;
  endtask : push
  // One host command, read data lands in rd
  task automatic hcmd(logic w, logic f, logic [ADDR_HI:ADDR_LO] a, logic [DATA_W-1:0] d);
    @(posedge clk);
    #1 cmd_valid = 1'h1;
    cmd_write = w;
    cmd_fifo = f;
    cmd_addr = a;
    cmd_wdata = d;
    rd = 32'hXXXX_XXXX;
    for (int k = 0; k < 50 && !cmd_ready; k++) @(posedge clk) #1;
    @(posedge clk) #1 cmd_valid = 1'h0;
    for (int k = 0; k < 50 && !cmd_ready; k++) begin
      if (rsp_valid) rd = rsp_data;
      @(posedge clk) #1;
    end
    chk("cmd_ready", 32'h1, {31'h0, cmd_ready});
    repeat (4) @(posedge clk);
    #1;
  endtask : hcmd
  task automatic t_rd32();
    push(32'h1111_2222);
    push(32'h3333_4444);
    chk("rx_ready full", 32'h0, {31'h0, rx_ready});
    hcmd(1'h0, 1'h1, 7'h78, 32'h0); chk("fifo rd 1", 32'h1111_2222, rd);
    hcmd(1'h0, 1'h1, 7'h00, 32'h0); chk("fifo rd 2", 32'h3333_4444, rd);
    hcmd(1'h0, 1'h1, 7'h30, 32'h0); chk("empty rd", 32'h0, rd);
    $display("t_rd32 done");
  endtask : t_rd32
  task automatic t_wr32();
    hcmd(1'h1, 1'h0, 7'h00, 32'h0BAD_0BAD); chk("plain wr", 32'h0, {31'h0, tx_valid});
    hcmd(1'h1, 1'h1, 7'h78, 32'hA5A5_0001);
    hcmd(1'h1, 1'h1, 7'h38, 32'hA5A5_0002);
    chk("tx head", 32'hA5A5_0001, tx_data);
    chk("no overrun", 32'h0, {31'h0, tx_overrun});
    hcmd(1'h1, 1'h1, 7'h40, 32'hA5A5_0003); chk("overrun", 32'h1, {31'h0, tx_overrun});
    tx_ready = 1'h1;
    @(posedge clk) #1 tx_ready = 1'h0;
    chk("tx second", 32'hA5A5_0002, tx_data);
    $display("t_wr32 done");
  endtask : t_wr32
  task automatic t_16();
    do_reset(1'h1);
    @(posedge clk) #1;
    chk("bus16_mode", 32'h1, {31'h0, bus16_mode});
    push(32'hAAAA_5555);
    hcmd(1'h0, 1'h1, 7'h78, 32'h0); chk("rd lo", 32'h5555, {16'h0, rd[15:0]});
    hcmd(1'h0, 1'h1, 7'h79, 32'h0); chk("rd hi", 32'hAAAA, {16'h0, rd[15:0]});
    chk("upper lanes", 32'h0, {31'h0, hi16});
    hcmd(1'h1, 1'h1, 7'h00, 32'hDEAD_1234);
    hcmd(1'h1, 1'h1, 7'h41, 32'hBEEF_5678);
    chk("tx 16", 32'h5678_1234, tx_data);
    hcmd(1'h0, 1'h0, 7'h00, 32'h0); chk("count rd", 32'h4, rd);
    $display("t_16 done");
  endtask : t_16
  // Serial PROM frame: select lead, first bit, two bits read back
  task automatic t_prom();
    int n = 0;
    @(posedge clk) #1 prom_start = 1'h1;
    sp_din = 1'h1;
    @(posedge clk) #1 prom_start = 1'h0;
    chk("prom busy", 32'h1, {31'h0, prom_busy && sp_sel});
    while (!sp_clk && n < 200) begin
      @(posedge clk) #1;
      n++;
    end
    chk("prom lead", 32'h1, {31'h0, n >= CSHCKH_CYC});
    chk("prom bit", 32'h1, {31'h0, sp_dout && !sp_oe_n});
    for (int k = 0; k < 1000 && !prom_done; k++) @(posedge clk) #1;
    chk("prom data", 32'h3, prom_rd_data);
    chk("prom idle", 32'h0, {30'h0, sp_sel, sp_clk});
    $display("t_prom done");
  endtask : t_prom
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    test_done();
  end
  initial begin
    {rx_valid, tx_ready, cmd_valid, cmd_write, cmd_fifo} = 5'h00;
    {rx_data, cmd_wdata, cmd_addr} = 71'h0;
    do_reset(1'h0);
    t_rd32();
    t_wr32();
    t_16();
    t_prom();
    test_done();
  end
endmodule : host_bus_fifo_direct_port_tb_top
